// ### hdl/ppfm_pkg.sv
package ppfm_pkg;
    // core clock
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned CLK_PERIOD_NS = 10;
    // presence sampling: pulse width and repeat period
    localparam int unsigned SAMPLE_PULSE_NS = 4000;
    localparam int unsigned SAMPLE_PERIOD_S = 1;
    localparam int unsigned SAMPLE_PULSE_CYC = SAMPLE_PULSE_NS / CLK_PERIOD_NS;
    localparam int unsigned SAMPLE_PERIOD_CYC = SAMPLE_PERIOD_S * CLK_HZ;
    localparam int unsigned TMR_W = 27;
    localparam logic [TMR_W-1:0] TMR_ZERO = 27'h000_0000;
    localparam logic [TMR_W-1:0] TMR_ONE = 27'h000_0001;
    // offset calibration time, arbitrary default
    localparam int unsigned CAL_CYC = 64;
    localparam int unsigned CAL_W = 16;
    localparam logic [CAL_W-1:0] CAL_ZERO = 16'h0000;
    localparam logic [CAL_W-1:0] CAL_ONE = 16'h0001;
    // bus idle state machine
    typedef enum logic [2:0] {
        PPFM_RUN = 3'b001,
        PPFM_CAL = 3'b010,
        PPFM_SLEEP = 3'b100
    } ppfm_pwr_type;
endpackage

// ### hdl/ppfm_sync.sv
`timescale 1ns/100ps
module ppfm_sync
    import ppfm_pkg::*;
#(
    parameter int unsigned WIDTH = 4
)
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // data
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // first stage is read only by the second
    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            meta_ff <= '0;
            sync_ff <= '0;
        end
        else
        begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
        end
    end

    assign sync_o = sync_ff;
endmodule // ppfm_sync

// ### hdl/ppfm_top.sv
`timescale 1ns/100ps
// Functional notes
// [RULE1] The presence pull-up is on only for a 4 us pulse once a second, and the level is read then.
// [RULE2] The host grounds the presence input, so low means installed and high means removed.
// [RULE3] Bus clock and data have weak pull-downs so both read low with no host attached.
// [RULE4] With both bus lines low the block runs offset calibration first and then goes to sleep.
// [RULE5] Ignition is commanded whenever any safety criterion is violated.
// [RULE6] While ignition is commanded the fuse pin is driven high.
// [RULE7] Otherwise the fuse pin is an input monitoring the secondary protector.
// [RULE8] A high fuse pin seen while monitoring sets the external permanent-fail flag.
// [RULE9] Ignition and the permanent-fail flag stay latched until power-on reset.
module ppfm_top
    import ppfm_pkg::*;
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // system present pin
    input wire logic system_present_input_i,
    output logic system_present_input_pullup_en_o,
    // bus line sensing
    input wire logic bus_clk_line_i,
    input wire logic bus_data_line_i,
    output logic bus_clk_pulldown_en_o,
    output logic bus_data_pulldown_en_o,
    // power mode
    input wire logic wake_i,
    output logic cal_active_o,
    output logic cal_done_o,
    output logic sleep_o,
    // safety criteria from protection logic
    input wire logic [3:0] safety_fault_i,
    // fuse pin, oe low while driving
    input wire logic fuse_pin_i,
    output logic fuse_pin_o,
    output logic fuse_pin_oe_n_o,
    // status
    output logic pack_present_o,
    output logic ignite_cmd_o,
    output logic external_permanent_fail_flag_o
);
    logic [3:0] sync_w;
    logic system_present_input_s;
    logic bclk_s;
    logic bdat_s;
    logic fuse_s;
    logic [TMR_W-1:0] tmr_ff;
    logic pulse_ff;
    logic present_ff;
    ppfm_pwr_type pwr_ff;
    ppfm_pwr_type nxt_pwr;
    logic [CAL_W-1:0] cal_ff;
    logic cal_done_ff;
    logic ignite_ff;
    logic external_permanent_fail_flag_ff;
    logic fuse_mon_ff;

    // bus lines pass inverted so the cleared synchroniser reads them as high, not idle,
    // otherwise every reset release would look like an idle bus and start calibration
    ppfm_sync #(
        .WIDTH(4)
    ) u_sync (
        .core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i),
        .async_i({system_present_input_i, ~bus_clk_line_i, ~bus_data_line_i, fuse_pin_i}),
        .sync_o(sync_w)
    );

    assign system_present_input_s = sync_w[3];
    assign bclk_s = ~sync_w[2];
    assign bdat_s = ~sync_w[1];
    assign fuse_s = sync_w[0];

    // one-second period counter; pull-up on for the first pulse cycles
    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            tmr_ff <= TMR_ZERO;
            pulse_ff <= 1'b0;
        end
        else
        begin
            if (tmr_ff == TMR_W'(SAMPLE_PERIOD_CYC - 1))
            begin
                tmr_ff <= TMR_ZERO;
            end
            else
            begin
                tmr_ff <= tmr_ff + TMR_ONE;
            end
            pulse_ff <= (tmr_ff < TMR_W'(SAMPLE_PULSE_CYC)); // RULE1
        end
    end

    // sample at the last pulse cycle so the synchroniser delay has settled
    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            present_ff <= 1'b0;
        end
        else if (pulse_ff && tmr_ff == TMR_W'(SAMPLE_PULSE_CYC))
        begin
            present_ff <= ~system_present_input_s; // RULE1 RULE2
        end
    end

    // bus idle detection and power mode
    always_comb
    begin
        nxt_pwr = pwr_ff;
        case (pwr_ff)
            PPFM_RUN:
            begin
                if (!bclk_s && !bdat_s)
                begin
                    nxt_pwr = PPFM_CAL; // RULE4
                end
            end
            PPFM_CAL:
            begin
                if (cal_ff == CAL_W'(CAL_CYC - 1))
                begin
                    nxt_pwr = PPFM_SLEEP; // RULE4
                end
            end
            PPFM_SLEEP:
            begin
                if (wake_i || bclk_s || bdat_s)
                begin
                    nxt_pwr = PPFM_RUN;
                end
            end
            default:
            begin
                nxt_pwr = PPFM_RUN;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            pwr_ff <= PPFM_RUN;
        end
        else
        begin
            pwr_ff <= nxt_pwr;
        end
    end

    // calibration runs to completion even if the bus wakes mid-way
    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            cal_ff <= CAL_ZERO;
            cal_done_ff <= 1'b0;
        end
        else
        begin
            if (pwr_ff == PPFM_CAL)
            begin
                cal_ff <= cal_ff + CAL_ONE;
            end
            else
            begin
                cal_ff <= CAL_ZERO;
            end
            cal_done_ff <= (pwr_ff == PPFM_CAL) && (cal_ff == CAL_W'(CAL_CYC - 1)); // RULE4
        end
    end

    // ignition latch; cleared only by power-on reset
    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            ignite_ff <= 1'b0;
        end
        else if (|safety_fault_i)
        begin
            ignite_ff <= 1'b1; // RULE5 RULE9
        end
    end

    // monitor only while not driving, else we would see our own drive
    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            fuse_mon_ff <= 1'b0;
        end
        else
        begin
            fuse_mon_ff <= ~ignite_ff & ~(|safety_fault_i); // RULE7
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            external_permanent_fail_flag_ff <= 1'b0;
        end
        else if (fuse_mon_ff && fuse_s)
        begin
            external_permanent_fail_flag_ff <= 1'b1; // RULE8 RULE9
        end
    end

    // registered pin outputs
    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            fuse_pin_o <= 1'b0;
            fuse_pin_oe_n_o <= 1'b1;
            system_present_input_pullup_en_o <= 1'b0;
            bus_clk_pulldown_en_o <= 1'b1;
            bus_data_pulldown_en_o <= 1'b1;
        end
        else
        begin
            fuse_pin_o <= ignite_ff; // RULE6
            fuse_pin_oe_n_o <= ~ignite_ff; // RULE6 RULE7
            system_present_input_pullup_en_o <= pulse_ff; // RULE1
            bus_clk_pulldown_en_o <= 1'b1; // RULE3
            bus_data_pulldown_en_o <= 1'b1; // RULE3
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            cal_active_o <= 1'b0;
            cal_done_o <= 1'b0;
            sleep_o <= 1'b0;
            pack_present_o <= 1'b0;
            ignite_cmd_o <= 1'b0;
            external_permanent_fail_flag_o <= 1'b0;
        end
        else
        begin
            cal_active_o <= (pwr_ff == PPFM_CAL);
            cal_done_o <= cal_done_ff;
            sleep_o <= (pwr_ff == PPFM_SLEEP);
            pack_present_o <= present_ff;
            ignite_cmd_o <= ignite_ff;
            external_permanent_fail_flag_o <= external_permanent_fail_flag_ff;
        end
    end
endmodule // ppfm_top

// ### verif/ppfm_top_assertions.sv
`timescale 1ns/100ps
module ppfm_top_assertions
    import ppfm_pkg::*;
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // watched ports
    input wire logic system_present_input_pullup_en_o,
    input wire logic pack_present_o,
    input wire logic cal_active_o,
    input wire logic cal_done_o,
    input wire logic [3:0] safety_fault_i,
    input wire logic fuse_pin_i,
    input wire logic fuse_pin_o,
    input wire logic fuse_pin_oe_n_o,
    input wire logic ignite_cmd_o,
    input wire logic external_permanent_fail_flag_o
);
    // run length of the pull-up pulse, too long for a repetition
    logic [8:0] hi_ff;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);
    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i || !system_present_input_pullup_en_o)
            hi_ff <= 9'h000;
        else
            hi_ff <= hi_ff + 9'h001;
    end
    a_pullup_pulse_width: assert property ($fell(system_present_input_pullup_en_o) |-> hi_ff == 9'h190)
        else $error("pull-up pulse width wrong");
    a_system_present_input_sample_time: assert property ($changed(pack_present_o) |-> $past(system_present_input_pullup_en_o, 2))
        else $error("presence sampled outside pulse");
    a_cal_then_done: assert property ($rose(cal_active_o) |-> ##64 cal_done_o)
        else $error("calibration length wrong");
    a_fault_ignites: assert property (|safety_fault_i |-> ##2 ignite_cmd_o)
        else $error("fault did not ignite");
    a_ignite_drives_pin: assert property (ignite_cmd_o |-> fuse_pin_o && !fuse_pin_oe_n_o)
        else $error("fuse pin not driven high");
    a_idle_pin_input: assert property (!ignite_cmd_o |-> fuse_pin_oe_n_o)
        else $error("fuse pin driven while idle");
    a_fire_sets_flag: assert property ((fuse_pin_i && !ignite_cmd_o && !(|safety_fault_i))[*3]
        |-> ##[0:4] external_permanent_fail_flag_o)
        else $error("permanent-fail flag not set");
    a_latch_hold: assert property ((ignite_cmd_o |=> ignite_cmd_o)
        and (external_permanent_fail_flag_o |=> external_permanent_fail_flag_o))
        else $error("latched status cleared");
endmodule // ppfm_top_assertions
bind ppfm_top ppfm_top_assertions u_chk (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
    .system_present_input_pullup_en_o(system_present_input_pullup_en_o), .pack_present_o(pack_present_o),
    .cal_active_o(cal_active_o), .cal_done_o(cal_done_o), .safety_fault_i(safety_fault_i),
    .fuse_pin_i(fuse_pin_i), .fuse_pin_o(fuse_pin_o), .fuse_pin_oe_n_o(fuse_pin_oe_n_o),
    .ignite_cmd_o(ignite_cmd_o),
    .external_permanent_fail_flag_o(external_permanent_fail_flag_o));

// ### verif/ppfm_far_side.sv
`timescale 1ns/100ps
module ppfm_far_side
(
    // pins from the block
    input wire logic pullup_en_i,
    input wire logic fuse_drv_i,
    input wire logic fuse_oe_n_i,
    // scenario controls
    input wire logic installed_i,
    input wire logic host_i,
    input wire logic prot_fire_i,
    // resolved wire levels
    output logic system_present_input_o,
    output logic clk_line_o,
    output logic data_line_o,
    output logic fuse_line_o
);
    // removed pack floats low once the pulse ends, not holding the last high
    assign system_present_input_o = installed_i ? 1'b0 : pullup_en_i;
    assign clk_line_o = host_i;
    assign data_line_o = host_i;
    // protector output drives the pin only while the block does not
    assign fuse_line_o = !fuse_oe_n_i ? fuse_drv_i : prot_fire_i;
endmodule // ppfm_far_side

// ### verif/test_pack_presence_fuse_monitor.sv
`timescale 1ns/100ps
module test_pack_presence_fuse_monitor;
    import ppfm_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, inst = 1'b1, host = 1'b1, fire = 1'b0, wake = 1'b0;
    logic [3:0] fault = 4'h0;
    logic system_present_input, cl, dl, fl, pu, cpd, dpd, ca, cd, slp, fo, foe, pp, ig, pf;
    logic [7:0] lf = 8'h11;
    int bad_count = 0, num_checks = 0, n;
    always #5 clk = ~clk;
    ppfm_top dut (.core_clk_i(clk), .reset_n_i(rst_n), .system_present_input_i(system_present_input),
        .system_present_input_pullup_en_o(pu), .bus_clk_line_i(cl), .bus_data_line_i(dl),
        .bus_clk_pulldown_en_o(cpd), .bus_data_pulldown_en_o(dpd), .wake_i(wake),
        .cal_active_o(ca), .cal_done_o(cd), .sleep_o(slp), .safety_fault_i(fault),
        .fuse_pin_i(fl), .fuse_pin_o(fo), .fuse_pin_oe_n_o(foe), .pack_present_o(pp),
        .ignite_cmd_o(ig), .external_permanent_fail_flag_o(pf));
    ppfm_far_side far (.pullup_en_i(pu), .fuse_drv_i(fo), .fuse_oe_n_i(foe),
        .installed_i(inst), .host_i(host), .prot_fire_i(fire), .system_present_input_o(system_present_input),
        .clk_line_o(cl), .data_line_o(dl), .fuse_line_o(fl));
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // bounded wait for a design flag, a timeout ends the run
    task automatic wait_hi(ref logic s, input int lim);
        n = 0;
        while (s !== 1'b1 && n < lim)
        begin
            @(negedge clk);
            n++;
        end
        if (n >= lim)
        begin
            bad_count++;
            conclude();
        end
    endtask
    task automatic reboot();
        @(negedge clk) rst_n = 1'b0;
        repeat (20) @(negedge clk);
        chk({cpd, dpd, foe, ig, pf}, 32'h0000_001C);
        rst_n = 1'b1;
    endtask
    initial
    begin
        reboot();
        wait_hi(pu, 10);
        n = 0;
        while (pu === 1'b1 && n < 500)
        begin
            @(negedge clk);
            n++;
        end
        chk(n, 32'h0000_0190);
        repeat (4) @(negedge clk);
        chk(pp, 1'b1);
        host = 1'b0;
        wait_hi(ca, 20);
        wait_hi(cd, 100);
        chk(slp, 1'b1);
        host = 1'b1;
        repeat (6) @(negedge clk);
        chk(slp, 1'b0);
        host = 1'b0;
        wait_hi(cd, 100);
        chk(slp, 1'b1);
        wake = 1'b1;
        repeat (2) @(negedge clk);
        chk(slp, 1'b0);
        wake = 1'b0;
        host = 1'b1;
        fire = 1'b1;
        repeat (8) @(negedge clk);
        chk({pf, ig, foe}, 32'h0000_0005);
        fire = 1'b0;
        repeat (8) @(negedge clk);
        chk(pf, 1'b1);
        for (int i = 0; i < 4; i++)
        begin
            reboot();
            lf = lfsr(lf);
            repeat (lf[3:0] + 2) @(negedge clk);
            fault = (4'h1 << i) | (lf[7:4] & {4{lf[0]}});
            @(negedge clk) fault = 4'h0;
            repeat (2) @(negedge clk);
            chk({ig, fo, foe}, 32'h0000_0006);
            repeat (20) @(negedge clk);
            chk({ig, pf}, 32'h0000_0002);
        end
        inst = 1'b0;
        reboot();
        repeat (410) @(negedge clk);
        chk(pp, 1'b0);
        chk({cpd, dpd}, 32'h0000_0003);
        conclude();
    end
endmodule // test_pack_presence_fuse_monitor
